// >>> verification/pwpa_tb.sv
// Self-checking bench for the pairing and alignment block.
// Assumes an AXI4-Lite slave on one 250 MHz clock, channel 7 absent.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] PRESENT = 8'h7F;
   localparam logic [7:0] CMASK = 8'h70;
   localparam logic [7:0] CTL = pwpa_pkg::CTL_ADDR;
   localparam logic [7:0] ALN = pwpa_pkg::ALIGN_ADDR;
   localparam logic [1:0] OK = pwpa_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = pwpa_pkg::RESP_SLVERR;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
   logic [7:0] aw_a = 8'h00, ar_a = 8'h00, en = 8'h00, ctl_m = 8'h00, aln_m = 8'h00;
   logic [31:0] w_d = 32'h0, seed = 32'h0000004C;
   logic [3:0] w_s = 4'hF;
   logic [63:0] per = 64'h0, duty = 64'h0, cnt = 64'h0;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
   logic [1:0] b_rsp, r_rsp;
   logic [31:0] r_d;
   logic [7:0] center;
   logic [3:0] concat;
   logic [63:0] p_per, p_duty, p_cnt;
   int err_count = 0;
   int n_tests = 0;
   pwpa_top #(.CHAN_PRESENT(PRESENT)) dut_u (.CLK_I(clk), .NRST_I(nrst),
      .S_AXI_AWADDR_I(aw_a), .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_rdy),
      .S_AXI_WDATA_I(w_d), .S_AXI_WSTRB_I(w_s), .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(w_rdy),
      .S_AXI_BRESP_O(b_rsp), .S_AXI_BVALID_O(b_v), .S_AXI_BREADY_I(b_r),
      .S_AXI_ARADDR_I(ar_a), .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(ar_rdy),
      .S_AXI_RDATA_O(r_d), .S_AXI_RRESP_O(r_rsp), .S_AXI_RVALID_O(r_v), .S_AXI_RREADY_I(r_r),
      .CH_ENABLE_I(en), .CH_PERIOD_I(per), .CH_DUTY_I(duty), .CH_COUNT_I(cnt),
      .CENTER_ALIGN_O(center), .CONCAT_O(concat), .PAIR_PERIOD_O(p_per),
      .PAIR_DUTY_O(p_duty), .PAIR_COUNT_O(p_cnt));
   initial
   begin
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Address and data offered together; each dropped once its own ready is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'h1;
      w_v <= 1'h1;
      b_r <= 1'h1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge clk);
         aw_ok = aw_ok | (aw_rdy === 1'h1);
         w_ok = w_ok | (w_rdy === 1'h1);
         if (aw_ok) aw_v <= 1'h0;
         if (w_ok) w_v <= 1'h0;
      end
      do @(posedge clk); while (b_v !== 1'h1);
      r = b_rsp;
      b_r <= 1'h0;
      // Let an edge pass so a following call never re-drives bready in this step
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      ar_a <= a;
      ar_v <= 1'h1;
      r_r <= 1'h1;
      do @(posedge clk); while (ar_rdy !== 1'h1);
      ar_v <= 1'h0;
      do @(posedge clk); while (r_v !== 1'h1);
      d = r_d;
      r = r_rsp;
      r_r <= 1'h0;
      @(posedge clk);
   endtask : rd
   task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check({d, 30'h0, r}, {24'h0, exp, 30'h0, OK});
   endtask : reg_chk
   // Even channel lands in the upper byte of each merged pair
   function automatic logic [63:0] joined(input logic [63:0] v);
      logic [63:0] o;
      o = 64'h0;
      for (int p = 0; p < 4; p++)
         if (ctl_m[4 + p]) o[16 * p +: 16] = {v[16 * p +: 8], v[16 * p + 8 +: 8]};
      return o;
   endfunction : joined
   // Pair busy: merged while either of its channels runs
   function automatic logic [3:0] busy_exp();
      logic [3:0] o;
      for (int p = 0; p < 4; p++)
         o[p] = ctl_m[4 + p] & (en[2 * p] | en[2 * p + 1]);
      return o;
   endfunction : busy_exp
   initial
   begin
      logic [1:0] r;
      logic [31:0] d;
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      reg_chk(CTL, pwpa_pkg::CTL_RESET);
      reg_chk(ALN, pwpa_pkg::ALIGN_RESET);
      for (int i = 0; i < 16; i++)
      begin
         d = (i == 0) ? 32'hFF : rnd();
         en <= 8'h00; // Joining changes only with channels stopped
         @(posedge clk);
         wr(CTL, d, r);
         check(64'(r), 64'(OK));
         ctl_m = d[7:0] & CMASK;
         d = rnd();
         en <= d[7:0];
         d = rnd();
         wr(ALN, d, r);
         check(64'(r), 64'(OK));
         aln_m = d[7:0] & PRESENT;
         reg_chk(CTL, ctl_m);
         reg_chk(ALN, aln_m);
         reg_chk(pwpa_pkg::STATUS_ADDR, {4'h0, busy_exp()});
         check(64'(concat), 64'(ctl_m[7:4]));
         check(64'(center), 64'(aln_m));
         per <= {rnd(), rnd()};
         duty <= {rnd(), rnd()};
         cnt <= {rnd(), rnd()};
         @(posedge clk);
         @(posedge clk);
         check(p_per, joined(per));
         check(p_duty, joined(duty));
         check(p_cnt, joined(cnt));
      end
      w_s <= 4'h0;
      wr(CTL, 32'hFF, r);
      w_s <= 4'hF;
      check(64'(r), 64'(OK));
      reg_chk(CTL, ctl_m);
      wr(8'h3C, 32'hFF, r);
      check(64'(r), 64'(ERR));
      rd(8'h3C, d, r);
      check({d, 30'h0, r}, {32'h0, 30'h0, ERR});
      wr(pwpa_pkg::STATUS_ADDR, 32'hFF, r);
      check(64'(r), 64'(ERR));
      print_verdict();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      err_count++;
      print_verdict();
   end
endmodule : testbench

// >>> verilog/pwpa_pair.sv
// Joins one pair of 8-bit channels into a 16-bit channel view.
// Assumes the even channel is wired to the hi_* side by the owner.
module pwpa_pair (
   input wire logic CLK_I,
   input wire logic NRST_I,
   pwpa_pair_if.joiner pair_if
);
   logic [15:0] period_next;
   logic [15:0] duty_next;
   logic [15:0] count_next;
   logic [15:0] period_reg;
   logic [15:0] duty_reg;
   logic [15:0] count_reg;

   // Even channel forms the high byte; unmerged pairs show zero
   assign period_next = pair_if.merged ? {pair_if.hi_period, pair_if.lo_period} : 16'h0000;
   assign duty_next = pair_if.merged ? {pair_if.hi_duty, pair_if.lo_duty} : 16'h0000;
   assign count_next = pair_if.merged ? {pair_if.hi_count, pair_if.lo_count} : 16'h0000;

   always_ff @(posedge CLK_I)
   begin
      if (!NRST_I)
      begin
         period_reg <= 16'h0000;
         duty_reg <= 16'h0000;
         count_reg <= 16'h0000;
      end
      else
      begin
         period_reg <= period_next;
         duty_reg <= duty_next;
         count_reg <= count_next;
      end
   end

   assign pair_if.period16 = period_reg;
   assign pair_if.duty16 = duty_reg;
   assign pair_if.count16 = count_reg;
endmodule : pwpa_pair

// >>> verilog/pwpa_pair_if.sv
// Signals between the top and one channel-pair joiner.
// Assumes all signals live on the block's single clock.
interface pwpa_pair_if;
   logic [7:0] hi_period;
   logic [7:0] lo_period;
   logic [7:0] hi_duty;
   logic [7:0] lo_duty;
   logic [7:0] hi_count;
   logic [7:0] lo_count;
   logic merged;
   logic [15:0] period16;
   logic [15:0] duty16;
   logic [15:0] count16;
   modport joiner (
      input hi_period, lo_period, hi_duty, lo_duty, hi_count, lo_count, merged,
      output period16, duty16, count16
   );
   modport owner (
      output hi_period, lo_period, hi_duty, lo_duty, hi_count, lo_count, merged,
      input period16, duty16, count16
   );
endinterface : pwpa_pair_if

// >>> verilog/pwpa_pkg.sv
// Constants shared by the pairing and alignment block.
// Assumes a 32-bit AXI4-Lite master with one-word registers.
package pwpa_pkg;
   localparam int unsigned NUM_CH = 8;
   localparam int unsigned NUM_PAIRS = 4;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned AXI_ADDR_W = 8;
   // Register indices; byte address is four times the index
   localparam logic [5:0] ALIGN_INDEX = 6'h04;
   localparam logic [5:0] CTL_INDEX = 6'h05;
   localparam logic [5:0] STATUS_INDEX = 6'h06;
   localparam logic [7:0] ALIGN_ADDR = {ALIGN_INDEX, 2'h0};
   localparam logic [7:0] CTL_ADDR = {CTL_INDEX, 2'h0};
   localparam logic [7:0] STATUS_ADDR = {STATUS_INDEX, 2'h0};
   // Control layout: concatenation bit of pair p sits at CONCAT_LSB + p
   localparam int unsigned CONCAT_LSB = 4;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] ALIGN_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pwpa_pkg

// >>> verilog/pwpa_top.sv
// Pairing and alignment control of an eight-channel modulator, AXI4-Lite slave.
// Assumes channel counters, periods, duties and enables on the same clock.
// Behaviour
// - Four concatenation bits each merge a channel pair into one 16-bit channel.
// - Pairs 6/7 and 4/5 merged: lower-numbered channel supplies the high bytes.
// - Pairs 2/3 and 0/1 merged: even channel supplies the high bytes.
// - Per-channel alignment bit: clear is left aligned, set is center aligned.
// - Alignment bits of missing channels ignore writes and read zero.
// - Concatenation bits of missing pairs ignore writes and read zero.
// - The control register may be read and written at any time.
//
// Implementation choice: register access over AXI4-Lite.
module pwpa_top #(
   parameter logic [7:0] CHAN_PRESENT = 8'hFF
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic [7:0] CH_ENABLE_I,
   input wire logic [63:0] CH_PERIOD_I,
   input wire logic [63:0] CH_DUTY_I,
   input wire logic [63:0] CH_COUNT_I,
   output logic [7:0] CENTER_ALIGN_O,
   output logic [3:0] CONCAT_O,
   output logic [63:0] PAIR_PERIOD_O,
   output logic [63:0] PAIR_DUTY_O,
   output logic [63:0] PAIR_COUNT_O
);
   logic [3:0] pair_present;
   logic [7:0] ctl_mask;
   logic [7:0] ctl_reg;
   logic [7:0] align_reg;
   logic [3:0] pair_busy;
   logic aw_got_reg;
   logic w_got_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic aw_fire;
   logic w_fire;
   logic wr_fire;
   logic ar_fire;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_sel_ctl;
   logic wr_sel_align;
   logic wr_mapped;
   logic rd_sel_ctl;
   logic rd_sel_align;
   logic rd_sel_status;
   logic rd_mapped;
   logic [31:0] rd_data;
   logic [7:0] ctl_next;
   logic [7:0] align_next;

   genvar p;
   generate
      for (p = 0; p < 4; p++)
      begin : g_pair
         pwpa_pair_if pif ();
         assign pair_present[p] = CHAN_PRESENT[2*p] & CHAN_PRESENT[2*p+1];
         // Even channel is always the high byte of a merged pair
         assign pif.hi_period = CH_PERIOD_I[16*p +: 8];
         assign pif.lo_period = CH_PERIOD_I[16*p+8 +: 8];
         assign pif.hi_duty = CH_DUTY_I[16*p +: 8];
         assign pif.lo_duty = CH_DUTY_I[16*p+8 +: 8];
         assign pif.hi_count = CH_COUNT_I[16*p +: 8];
         assign pif.lo_count = CH_COUNT_I[16*p+8 +: 8];
         assign pif.merged = CONCAT_O[p];
         assign PAIR_PERIOD_O[16*p +: 16] = pif.period16;
         assign PAIR_DUTY_O[16*p +: 16] = pif.duty16;
         assign PAIR_COUNT_O[16*p +: 16] = pif.count16;
         // Merged pair with a running channel: software broke the enable order
         assign pair_busy[p] = CONCAT_O[p] & (CH_ENABLE_I[2*p] | CH_ENABLE_I[2*p+1]);
         pwpa_pair u_pair (
            .CLK_I(CLK_I),
            .NRST_I(NRST_I),
            .pair_if(pif)
         );
      end
   endgenerate

   assign ctl_mask = {pair_present, 4'h0};

   // Write channel: address and data taken in either order
   assign S_AXI_AWREADY_O = !aw_got_reg && !bvalid_reg;
   assign S_AXI_WREADY_O = !w_got_reg && !bvalid_reg;
   assign aw_fire = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
   assign w_fire = S_AXI_WVALID_I && S_AXI_WREADY_O;
   assign wr_fire = (aw_got_reg || aw_fire) && (w_got_reg || w_fire);
   assign wr_addr = aw_got_reg ? awaddr_reg : S_AXI_AWADDR_I;
   assign wr_data = w_got_reg ? wdata_reg : S_AXI_WDATA_I;
   assign wr_strb = w_got_reg ? wstrb_reg : S_AXI_WSTRB_I;
   assign wr_sel_ctl = wr_addr[7:2] == pwpa_pkg::CTL_INDEX;
   assign wr_sel_align = wr_addr[7:2] == pwpa_pkg::ALIGN_INDEX;
   // Status is read-only, so a write to it is refused
   assign wr_mapped = wr_sel_ctl || wr_sel_align;
   // No gating by channel enables or mode: writable at any time
   assign ctl_next = (wr_fire && wr_sel_ctl && wr_strb[0]) ?
      (wr_data[7:0] & ctl_mask) : ctl_reg;
   assign align_next = (wr_fire && wr_sel_align && wr_strb[0]) ?
      (wr_data[7:0] & CHAN_PRESENT) : align_reg;

   always_ff @(posedge CLK_I)
   begin
      if (!NRST_I)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= pwpa_pkg::RESP_OKAY;
         ctl_reg <= pwpa_pkg::CTL_RESET;
         align_reg <= pwpa_pkg::ALIGN_RESET;
      end
      else
      begin
         aw_got_reg <= (aw_got_reg || aw_fire) && !wr_fire;
         w_got_reg <= (w_got_reg || w_fire) && !wr_fire;
         if (aw_fire)
            awaddr_reg <= S_AXI_AWADDR_I;
         if (w_fire)
         begin
            wdata_reg <= S_AXI_WDATA_I;
            wstrb_reg <= S_AXI_WSTRB_I;
         end
         if (wr_fire)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? pwpa_pkg::RESP_OKAY : pwpa_pkg::RESP_SLVERR;
         end
         else if (S_AXI_BREADY_I)
            bvalid_reg <= 1'b0;
         ctl_reg <= ctl_next;
         align_reg <= align_next;
      end
   end

   // Read channel: one read at a time, answer one cycle after acceptance
   assign S_AXI_ARREADY_O = !rvalid_reg;
   assign ar_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   assign rd_sel_ctl = S_AXI_ARADDR_I[7:2] == pwpa_pkg::CTL_INDEX;
   assign rd_sel_align = S_AXI_ARADDR_I[7:2] == pwpa_pkg::ALIGN_INDEX;
   assign rd_sel_status = S_AXI_ARADDR_I[7:2] == pwpa_pkg::STATUS_INDEX;
   assign rd_mapped = rd_sel_ctl || rd_sel_align || rd_sel_status;
   assign rd_data = rd_sel_ctl ? {24'h000000, ctl_reg} :
      rd_sel_align ? {24'h000000, align_reg} :
      rd_sel_status ? {28'h0000000, pair_busy} : 32'h00000000;

   always_ff @(posedge CLK_I)
   begin
      if (!NRST_I)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg <= pwpa_pkg::RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end
      else if (ar_fire)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_mapped ? pwpa_pkg::RESP_OKAY : pwpa_pkg::RESP_SLVERR;
         rdata_reg <= rd_data;
      end
      else if (S_AXI_RREADY_I)
         rvalid_reg <= 1'b0;
   end

   assign S_AXI_BVALID_O = bvalid_reg;
   assign S_AXI_BRESP_O = bresp_reg;
   assign S_AXI_RVALID_O = rvalid_reg;
   assign S_AXI_RRESP_O = rresp_reg;
   assign S_AXI_RDATA_O = rdata_reg;
   // Clear bit left aligned, set bit center aligned
   assign CENTER_ALIGN_O = align_reg;
   assign CONCAT_O = ctl_reg[pwpa_pkg::CONCAT_LSB +: 4];

   a_concat_absent: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      (CONCAT_O & ~pair_present) == 4'h0)
      else $error("Concatenation bit set for a missing pair");
   a_align_absent: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      ar_fire && rd_sel_align |=> (S_AXI_RDATA_O[7:0] & ~CHAN_PRESENT) == 8'h00)
      else $error("Alignment bit of a missing channel read nonzero");
   a_align_write: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      wr_fire && wr_sel_align && wr_strb[0]
      |=> CENTER_ALIGN_O == ($past(wr_data[7:0]) & CHAN_PRESENT))
      else $error("Alignment output does not follow the write");
   a_ctl_anytime: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      wr_fire && wr_sel_ctl && wr_strb[0] |=> ctl_reg == ($past(wr_data[7:0]) & ctl_mask))
      else $error("Control write was not taken");
   a_high_byte_upper: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      CONCAT_O[2] |=> PAIR_PERIOD_O[47:40] == $past(CH_PERIOD_I[39:32])
      && PAIR_PERIOD_O[39:32] == $past(CH_PERIOD_I[47:40])
      && PAIR_DUTY_O[47:40] == $past(CH_DUTY_I[39:32]))
      else $error("Channel four is not the high byte");
   a_high_byte_lower: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      CONCAT_O[0] |=> PAIR_DUTY_O[15:8] == $past(CH_DUTY_I[7:0])
      && PAIR_COUNT_O[7:0] == $past(CH_COUNT_I[15:8]))
      else $error("Channel zero is not the high byte");
   a_merge_width: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      !CONCAT_O[1] ##1 !CONCAT_O[1] |-> PAIR_COUNT_O[31:16] == 16'h0000)
      else $error("Unmerged pair shows a 16-bit value");
   a_write_answer: assert property (@(posedge CLK_I) disable iff (!NRST_I)
      wr_fire |=> S_AXI_BVALID_O && S_AXI_BRESP_O == ($past(wr_mapped) ? 2'h0 : 2'h2))
      else $error("Write response missing or wrong");
endmodule : pwpa_top
